// ===== calibration_otp_loader.sv
// calibration loader: otp shadow registers, wake-time tune copy, always-on retention
//
// Summary of operation
// [RQ1] Every reset copies the 64-bit identifier from otp words 0x000/0x001 unaided.
// [RQ2] On wakeup, if enabled, the 40-bit regulator tune is copied from 0x004/0x005; the code does so only when retention is also enabled.
// [RQ3] Host programs channel 2 transmit power from all bytes of word 0x013.
// [RQ4] Host programs channel 5 transmit power from all bytes of word 0x019.
// [RQ5] Host takes pulse delay from word 0x01e, byte 3 channel 2, byte 2 channel 5.
// [RQ6] Host reads word 0x01d byte 0 as temperature, byte 1 as voltage reference.
// [RQ7] Host takes antenna delay from 0x01c: bytes 1:0 channel 5, 3:2 channel 2.
// [RQ8] Word 0x01e byte 0 bits 4:0 hold crystal trim, byte 1 otp revision.
// [RQ9] Word 0x01b holds pulse counts: channel 2 upper half, channel 5 lower half.
// [RQ10] The spi mode word lives at otp address 0x400.
// [RQ11] Always-on store keeps config while regulators are off, saved and restored.
// [RQ12] Supply voltage and die temperature monitor results are readable.
// [RQ13] Word 0x007 holds lot code, word 0x006 part code, both read-only.
// [RQ14] Host finishes channel otp reads and programming before enabling transmission.
`include "calib_regs.svh"

module calibration_otp_loader (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    // register port
    input  wire logic [10:0]           i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [31:0]           o_rdata,
    // otp array, data valid the cycle after the read strobe
    output calib_pkg::otp_req_t        o_otp_req,
    input  wire logic [31:0]           i_otp_rdata,
    // power state and analog monitors, asynchronous
    input  wire logic                  i_sleep,
    input  wire logic [7:0]            i_mon_volt,
    input  wire logic [7:0]            i_mon_temp,
    // applied settings
    output logic      [63:0]           o_extended_unique_id,
    output logic      [39:0]           o_regulator_tune,
    output logic      [4:0]            o_crystal_trim,
    output logic                       o_busy
);

    // =================================================================
    // input synchronisers
    logic               sleep_s;
    logic               sleep_d_q;
    calib_pkg::monitor_t mon_s;

    sync2 #(.W(1)) u_sync_sleep (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_async   (i_sleep),
        .o_sync    (sleep_s)
    );

    // adc codes are assumed to move slowly; a torn sample lasts one cycle at most
    sync2 #(.W(16)) u_sync_mon (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_async   ({i_mon_temp, i_mon_volt}),
        .o_sync    (mon_s)
    );

    wire sleep_rise = sleep_s & ~sleep_d_q;
    wire wake_fall  = ~sleep_s & sleep_d_q;

    // =================================================================
    // state
    logic [31:0] shadow_q [`NUM_ENTRIES];
    logic [31:0] ctrl_q;
    logic [31:0] config_q;
    logic [31:0] aon_ctrl_q;
    logic [31:0] aon_config_q;
    logic        boot_q;
    logic        wake_pend_q;
    logic        run_wake_q;
    logic        ident_valid_q;
    logic        tune_applied_q;
    calib_pkg::monitor_t mon_q;

    // =================================================================
    // fetch sequencer
    calib_pkg::otp_cap_t cap;
    logic                fetch_busy;
    logic                fetch_start;
    logic [3:0]          first_idx;
    logic [3:0]          last_idx;

    // a boot load runs before any pending wake load
    assign fetch_start = ~fetch_busy & (boot_q | wake_pend_q);
    assign first_idx   = boot_q ? `IDX_IDENT_LOW : `IDX_TUNE_LOW;
    assign last_idx    = `IDX_TUNE_HIGH;

    // ctrl still reads as cleared at the wake edge, so the option is taken
    // from the retained copy that the same edge restores
    wire tune_on_wake = aon_ctrl_q[`CTRL_AON_ENABLE] ? aon_ctrl_q[`CTRL_TUNE_ON_WAKE]
                                                     : ctrl_q[`CTRL_TUNE_ON_WAKE];

    otp_fetch u_fetch (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_start   (fetch_start),
        .i_first   (first_idx),
        .i_last    (last_idx),
        .o_req     (o_otp_req),
        .o_cap     (cap),
        .o_busy    (fetch_busy)
    );

    // =================================================================
    // shadow capture and load control

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < `NUM_ENTRIES; i++)
                shadow_q[i] <= 32'h0000_0000;
        end
        else if (cap.en)
        begin
            shadow_q[cap.idx] <= i_otp_rdata; // RQ1 RQ9 RQ10 RQ13 RQ8
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            boot_q      <= 1'b1; // RQ1
            run_wake_q  <= 1'b0;
            wake_pend_q <= 1'b0;
        end
        else
        begin
            if (fetch_start)
            begin
                boot_q     <= 1'b0;
                run_wake_q <= ~boot_q;
            end
            // a wake arriving as a pending one starts still counts
            if (wake_fall && tune_on_wake)
                wake_pend_q <= 1'b1; // RQ2
            else if (fetch_start && !boot_q)
                wake_pend_q <= 1'b0;
        end
    end

    // =================================================================
    // identifier and tune application
    wire last_cap = cap.en & (cap.idx == `IDX_TUNE_HIGH);

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ident_valid_q    <= 1'b0;
            tune_applied_q   <= 1'b0;
            o_regulator_tune <= 40'h00_0000_0000;
        end
        else
        begin
            if (cap.en && cap.idx == `IDX_IDENT_HIGH)
                ident_valid_q <= 1'b1; // RQ1
            if (last_cap && run_wake_q)
            begin
                o_regulator_tune <= {i_otp_rdata[7:0], shadow_q[`IDX_TUNE_LOW]}; // RQ2
                tune_applied_q   <= 1'b1;
            end
        end
    end

    // =================================================================
    // always-on store
    // volatile config is lost while regulators are off; the saved copy
    // comes back on wake only when retention was enabled at sleep entry
    wire ctrl_hit   = i_wr & (i_addr == `REG_CTRL) & ~sleep_s;
    wire config_hit = i_wr & (i_addr == `REG_CONFIG) & ~sleep_s;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sleep_d_q    <= 1'b0;
            ctrl_q       <= `CTRL_RESET;
            config_q     <= `CONFIG_RESET;
            aon_ctrl_q   <= `CTRL_RESET;
            aon_config_q <= `CONFIG_RESET;
        end
        else
        begin
            sleep_d_q <= sleep_s;
            if (sleep_rise)
            begin
                if (ctrl_q[`CTRL_AON_ENABLE])
                begin
                    aon_ctrl_q   <= ctrl_q; // RQ11
                    aon_config_q <= config_q; // RQ11
                end
                else
                begin
                    // without retention nothing stale may come back on wake
                    aon_ctrl_q   <= `CTRL_RESET;
                    aon_config_q <= `CONFIG_RESET;
                end
                ctrl_q   <= `CTRL_RESET;
                config_q <= `CONFIG_RESET;
            end
            else if (wake_fall && aon_ctrl_q[`CTRL_AON_ENABLE])
            begin
                ctrl_q   <= aon_ctrl_q; // RQ11
                config_q <= aon_config_q; // RQ11
            end
            else
            begin
                if (ctrl_hit)
                    ctrl_q <= i_wdata;
                if (config_hit)
                    config_q <= i_wdata;
            end
        end
    end

    // =================================================================
    // register read decode
    logic        rd_hit;
    logic [3:0]  rd_idx;
    logic [31:0] status_w;
    logic [31:0] reg_w;

    function automatic logic [4:0] entry_of(input logic [10:0] a);
        case (a)
            `OTP_IDENT_LOW:      entry_of = {1'b1, `IDX_IDENT_LOW};
            `OTP_IDENT_HIGH:     entry_of = {1'b1, `IDX_IDENT_HIGH};
            `OTP_REG_TUNE_LOW:   entry_of = {1'b1, `IDX_TUNE_LOW};
            `OTP_REG_TUNE_HIGH:  entry_of = {1'b1, `IDX_TUNE_HIGH};
            `OTP_PART_CODE:      entry_of = {1'b1, `IDX_PART_CODE};
            `OTP_LOT_CODE:       entry_of = {1'b1, `IDX_LOT_CODE};
            `OTP_CH2_TX_POWER:   entry_of = {1'b1, `IDX_CH2_TX_POWER};
            `OTP_CH5_TX_POWER:   entry_of = {1'b1, `IDX_CH5_TX_POWER};
            `OTP_PULSE_COUNTS:   entry_of = {1'b1, `IDX_PULSE_COUNTS};
            `OTP_ANTENNA_DELAYS: entry_of = {1'b1, `IDX_ANTENNA_DELAYS};
            `OTP_COMP_REFS:      entry_of = {1'b1, `IDX_COMP_REFS};
            `OTP_DELAY_TRIM:     entry_of = {1'b1, `IDX_DELAY_TRIM};
            `OTP_SERIAL_MODE:    entry_of = {1'b1, `IDX_SERIAL_MODE};
            default:             entry_of = 5'h00;
        endcase
    endfunction

    assign {rd_hit, rd_idx} = entry_of(i_addr); // RQ13

    // busy and asleep follow live levels; the valid and applied bits stay set
    always_comb
    begin
        status_w                   = 32'h0000_0000;
        status_w[`ST_BUSY]         = fetch_busy;
        status_w[`ST_IDENT_VALID]  = ident_valid_q;
        status_w[`ST_TUNE_APPLIED] = tune_applied_q;
        status_w[`ST_ASLEEP]       = sleep_s;
    end

    always_comb
    begin
        reg_w = 32'h0000_0000;
        if (rd_hit)
            reg_w = shadow_q[rd_idx];
        else
        begin
            case (i_addr)
                `REG_CTRL:      reg_w = ctrl_q;
                `REG_STATUS:    reg_w = status_w;
                `REG_MONITOR:   reg_w = {16'h0000, mon_q}; // RQ12
                `REG_TUNE_LOW:  reg_w = o_regulator_tune[31:0];
                `REG_TUNE_HIGH: reg_w = {24'h00_0000, o_regulator_tune[39:32]};
                `REG_CONFIG:    reg_w = config_q;
                default:        reg_w = 32'h0000_0000;
            endcase
        end
    end

    // =================================================================
    // applied settings and read data
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rdata              <= 32'h0000_0000;
            mon_q                <= '0;
            o_extended_unique_id <= 64'h0000_0000_0000_0000;
            o_crystal_trim       <= 5'h00;
            o_busy               <= 1'b0;
        end
        else
        begin
            o_rdata  <= i_rd ? reg_w : 32'h0000_0000;
            mon_q    <= mon_s; // RQ12
            o_busy   <= fetch_busy | boot_q;
            o_extended_unique_id <= {shadow_q[`IDX_IDENT_HIGH], shadow_q[`IDX_IDENT_LOW]}; // RQ1
            o_crystal_trim <= shadow_q[`IDX_DELAY_TRIM][`TRIM_MSB:`TRIM_LSB]; // RQ8
        end
    end

endmodule // calibration_otp_loader

// ===== calib_regs.svh
// offsets, field positions, reset values and counts of the calibration loader
`ifndef CALIB_REGS_SVH
`define CALIB_REGS_SVH

// =====================================================================
// otp word addresses, also the register offsets seen on the bus
`define OTP_IDENT_LOW       11'h000
`define OTP_IDENT_HIGH      11'h001
`define OTP_REG_TUNE_LOW    11'h004
`define OTP_REG_TUNE_HIGH   11'h005
`define OTP_PART_CODE       11'h006
`define OTP_LOT_CODE        11'h007
`define OTP_CH2_TX_POWER    11'h013
`define OTP_CH5_TX_POWER    11'h019
`define OTP_PULSE_COUNTS    11'h01b
`define OTP_ANTENNA_DELAYS  11'h01c
`define OTP_COMP_REFS       11'h01d
`define OTP_DELAY_TRIM      11'h01e
`define OTP_SERIAL_MODE     11'h400

// =====================================================================
// block registers
`define REG_CTRL            11'h020
`define REG_STATUS          11'h021
`define REG_MONITOR         11'h022
`define REG_TUNE_LOW        11'h023
`define REG_TUNE_HIGH       11'h024
`define REG_CONFIG          11'h025

// =====================================================================
// shadow entry indices, in fetch order
`define IDX_IDENT_LOW       4'h0
`define IDX_IDENT_HIGH      4'h1
`define IDX_PART_CODE       4'h2
`define IDX_LOT_CODE        4'h3
`define IDX_CH2_TX_POWER    4'h4
`define IDX_CH5_TX_POWER    4'h5
`define IDX_PULSE_COUNTS    4'h6
`define IDX_ANTENNA_DELAYS  4'h7
`define IDX_COMP_REFS       4'h8
`define IDX_DELAY_TRIM      4'h9
`define IDX_SERIAL_MODE     4'ha
`define IDX_TUNE_LOW        4'hb
`define IDX_TUNE_HIGH       4'hc
`define NUM_ENTRIES         13

// =====================================================================
// field positions and reset values
`define CTRL_TUNE_ON_WAKE   0
`define CTRL_AON_ENABLE     1
`define ST_BUSY             0
`define ST_IDENT_VALID      1
`define ST_TUNE_APPLIED     2
`define ST_ASLEEP           3
`define TRIM_MSB            4
`define TRIM_LSB            0
`define CTRL_RESET          32'h0000_0000
`define CONFIG_RESET        32'h0000_0000

`endif

// ===== calib_pkg.sv
// types shared by the calibration loader modules
package calib_pkg;

    typedef struct packed {
        logic        rd;
        logic [10:0] addr;
    } otp_req_t;

    typedef struct packed {
        logic       en;
        logic [3:0] idx;
    } otp_cap_t;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] volt;
    } monitor_t;

    typedef enum logic [1:0] {
        F_IDLE  = 2'b00,
        F_RUN   = 2'b01,
        F_DRAIN = 2'b10
    } fetch_state_t;

endpackage

// ===== sync2.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // sync2

// ===== otp_fetch.sv
// walks a range of shadow entries, one otp read per cycle, data one cycle later
`include "calib_regs.svh"

module otp_fetch (
    input  wire logic               i_clk_sys,
    input  wire logic               i_nrst,
    input  wire logic               i_start,
    input  wire logic [3:0]         i_first,
    input  wire logic [3:0]         i_last,
    output calib_pkg::otp_req_t     o_req,
    output calib_pkg::otp_cap_t     o_cap,
    output logic                    o_busy
);
    calib_pkg::fetch_state_t state_q;
    logic [3:0]              idx_q;
    logic [3:0]              last_q;
    logic [3:0]              req_idx_q;
    logic [10:0]             addr_w;

    function automatic logic [10:0] addr_of(input logic [3:0] idx);
        case (idx)
            `IDX_IDENT_LOW:      addr_of = `OTP_IDENT_LOW;
            `IDX_IDENT_HIGH:     addr_of = `OTP_IDENT_HIGH;
            `IDX_PART_CODE:      addr_of = `OTP_PART_CODE;
            `IDX_LOT_CODE:       addr_of = `OTP_LOT_CODE;
            `IDX_CH2_TX_POWER:   addr_of = `OTP_CH2_TX_POWER;
            `IDX_CH5_TX_POWER:   addr_of = `OTP_CH5_TX_POWER;
            `IDX_PULSE_COUNTS:   addr_of = `OTP_PULSE_COUNTS;
            `IDX_ANTENNA_DELAYS: addr_of = `OTP_ANTENNA_DELAYS;
            `IDX_COMP_REFS:      addr_of = `OTP_COMP_REFS;
            `IDX_DELAY_TRIM:     addr_of = `OTP_DELAY_TRIM;
            `IDX_SERIAL_MODE:    addr_of = `OTP_SERIAL_MODE;
            `IDX_TUNE_LOW:       addr_of = `OTP_REG_TUNE_LOW;
            default:             addr_of = `OTP_REG_TUNE_HIGH;
        endcase
    endfunction

    assign addr_w = addr_of(idx_q);

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= calib_pkg::F_IDLE;
            idx_q   <= 4'h0;
            last_q  <= 4'h0;
            req_idx_q <= 4'h0;
            o_req   <= '0;
            o_cap   <= '0;
            o_busy  <= 1'b0;
        end
        else
        begin
            o_req.rd <= 1'b0;
            o_cap.en <= o_req.rd;
            o_cap.idx <= req_idx_q;
            case (state_q)
                calib_pkg::F_IDLE:
                begin
                    if (i_start)
                    begin
                        idx_q   <= i_first;
                        last_q  <= i_last;
                        o_busy  <= 1'b1;
                        state_q <= calib_pkg::F_RUN;
                    end
                end
                calib_pkg::F_RUN:
                begin
                    // one read per cycle; the entry index rides along to the capture
                    o_req.rd   <= 1'b1;
                    o_req.addr <= addr_w;
                    req_idx_q  <= idx_q;
                    if (idx_q == last_q)
                        state_q <= calib_pkg::F_DRAIN;
                    else
                        idx_q <= idx_q + 4'h1;
                end
                calib_pkg::F_DRAIN:
                begin
                    // busy stays high until the last word has been captured
                    if (!o_cap.en && !o_req.rd)
                    begin
                        o_busy  <= 1'b0;
                        state_q <= calib_pkg::F_IDLE;
                    end
                end
                default: state_q <= calib_pkg::F_IDLE;
            endcase
        end
    end
endmodule // otp_fetch

// ===== calib_loader_props.sv
// port-level properties of the calibration loader
module calib_loader_props (
    input  wire logic                i_clk_sys,
    input  wire logic                i_nrst,
    input  wire logic                i_rd,
    input  wire logic [31:0]         o_rdata,
    input  wire calib_pkg::otp_req_t o_otp_req,
    input  wire logic [31:0]         i_otp_rdata,
    input  wire logic [63:0]         o_extended_unique_id,
    input  wire logic [39:0]         o_regulator_tune,
    input  wire logic [4:0]          o_crystal_trim,
    input  wire logic                o_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // ====================
    // helper: which otp word is on the data bus in this cycle
    logic        rd_q;
    logic [10:0] addr_q;
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rd_q   <= 1'b0;
            addr_q <= 11'h000;
        end
        else
        begin
            rd_q   <= o_otp_req.rd;
            addr_q <= o_otp_req.addr;
        end
    end
    wire logic cap_lo   = rd_q && addr_q == 11'h000;
    wire logic cap_hi   = rd_q && addr_q == 11'h001;
    wire logic cap_trim = rd_q && addr_q == 11'h01e;
    wire logic cap_tune = rd_q && addr_q == 11'h005;

    // ====================
    // properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_rd(logic [10:0] a);
        o_otp_req.rd && o_otp_req.addr == a;
    endsequence

    a_boot_start: assert property ($rose(i_nrst) |-> ##[1:6] s_rd(11'h000))
        else $error("boot load did not start after reset");
    a_boot_order: assert property (s_rd(11'h000) |=> s_rd(11'h001) ##1 s_rd(11'h006)
        ##1 s_rd(11'h007))
        else $error("boot load order broken");
    a_tune_pair: assert property (s_rd(11'h004) |=> s_rd(11'h005))
        else $error("tune words not read back to back");
    a_id_low_copy: assert property (cap_lo |-> ##2
        o_extended_unique_id[31:0] == $past(i_otp_rdata, 2))
        else $error("identifier low word not copied");
    a_id_high_copy: assert property (cap_hi |-> ##2
        o_extended_unique_id[63:32] == $past(i_otp_rdata, 2))
        else $error("identifier high word not copied");
    a_trim_copy: assert property (cap_trim |-> ##2
        o_crystal_trim == $past(i_otp_rdata[4:0], 2))
        else $error("crystal trim not taken from byte 0");
    a_tune_source: assert property ($changed(o_regulator_tune) |-> $past(cap_tune))
        else $error("regulator tune changed without a tune capture");
    a_read_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_fetch_busy: assert property (o_otp_req.rd |-> o_busy)
        else $error("otp read while not busy");
endmodule // calib_loader_props

// ===== otp_array_model.sv
// otp array model: one word per read, data only in the cycle after the read
module otp_array_model (
    input  wire logic                i_clk_sys,
    input  wire calib_pkg::otp_req_t i_req,
    output logic [31:0]              o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ====================
    // contents follow the address so every word differs
    function automatic logic [31:0] word_at(input logic [10:0] a);
        return {5'h15, a, ~a[7:0], a[7:0] ^ 8'h5a};
    endfunction

    initial o_rdata = 32'h0;
    // outside the answer cycle the bus toggles, so a sample one cycle late cannot match
    always @(posedge i_clk_sys)
        o_rdata <= i_req.rd ? word_at(i_req.addr) : ~o_rdata;
endmodule // otp_array_model

// ===== calibration_otp_loader_tb.sv
// self-checking bench for the calibration loader
`include "calib_regs.svh"

module calibration_otp_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ====================
    // signals
    logic                i_clk_sys;
    logic                i_nrst;
    logic [10:0]         i_addr;
    logic [31:0]         i_wdata;
    logic                i_wr;
    logic                i_rd;
    logic [31:0]         o_rdata;
    calib_pkg::otp_req_t o_otp_req;
    logic [31:0]         i_otp_rdata;
    logic                i_sleep;
    logic [7:0]          i_mon_volt;
    logic [7:0]          i_mon_temp;
    logic [63:0]         o_extended_unique_id;
    logic [39:0]         o_regulator_tune;
    logic [4:0]          o_crystal_trim;
    logic                o_busy;
    int                  bad_count;
    int                  tests_run;
    int                  seed;
    logic [31:0]         rd_val;
    logic [31:0]         rnd;
    logic [31:0]         ew;
    logic [10:0]         otp_tab [13] = '{`OTP_IDENT_LOW, `OTP_IDENT_HIGH, `OTP_REG_TUNE_LOW,
        `OTP_REG_TUNE_HIGH, `OTP_PART_CODE, `OTP_LOT_CODE, `OTP_CH2_TX_POWER, `OTP_CH5_TX_POWER,
        `OTP_PULSE_COUNTS, `OTP_ANTENNA_DELAYS, `OTP_COMP_REFS, `OTP_DELAY_TRIM, `OTP_SERIAL_MODE};

    calibration_otp_loader dut_u (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_otp_req(o_otp_req),
        .i_otp_rdata(i_otp_rdata), .i_sleep(i_sleep), .i_mon_volt(i_mon_volt),
        .i_mon_temp(i_mon_temp), .o_extended_unique_id(o_extended_unique_id),
        .o_regulator_tune(o_regulator_tune), .o_crystal_trim(o_crystal_trim), .o_busy(o_busy));

    otp_array_model model_u (.i_clk_sys(i_clk_sys), .i_req(o_otp_req), .o_rdata(i_otp_rdata));

    // ====================
    // helpers
    function automatic logic [31:0] exp_word(input logic [10:0] a);
        return {5'h15, a, ~a[7:0], a[7:0] ^ 8'h5a};
    endfunction

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_check(input string what, input logic [10:0] a, input logic [31:0] exp);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
        check(what, {32'h0, exp}, {32'h0, rd_val});
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        // busy rises a few edges after a wake, so look only once it has
        repeat (6) @(posedge i_clk_sys);
        #1;
        while (o_busy !== 1'b0 && n < 200)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        check("busy", 64'h0, {63'h0, o_busy});
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ====================
    // clock and watchdog
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // the whole sequence needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        bad_count++;
        print_verdict();
    end

    // ====================
    // main sequence
    initial
    begin
        seed = 32'h16155359;
        bad_count = 0;
        tests_run = 0;
        i_nrst = 1'b0;
        i_addr = 11'h000;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_sleep = 1'b0;
        i_mon_volt = 8'h00;
        i_mon_temp = 8'h00;
        repeat (12) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        wait_idle();
        check("uid", {exp_word(11'h001), exp_word(11'h000)}, o_extended_unique_id);
        ew = exp_word(`OTP_DELAY_TRIM);
        check("trim", {59'h0, ew[4:0]}, {59'h0, o_crystal_trim});
        check("tune boot", 64'h0, {24'h0, o_regulator_tune});
        rd_check("status", `REG_STATUS, 32'h2);
        rd_check("ctrl", `REG_CTRL, `CTRL_RESET);
        rd_check("config", `REG_CONFIG, `CONFIG_RESET);
        foreach (otp_tab[i])
            rd_check("otp", otp_tab[i], exp_word(otp_tab[i]));
        // read-only words and an unmapped address
        rnd = $random(seed);
        bus_wr(`OTP_PART_CODE, rnd);
        bus_wr(`OTP_LOT_CODE, ~rnd);
        rd_check("part", `OTP_PART_CODE, exp_word(`OTP_PART_CODE));
        rd_check("lot", `OTP_LOT_CODE, exp_word(`OTP_LOT_CODE));
        rd_check("unmapped", 11'h3ff, 32'h0);
        @(posedge i_clk_sys);
        i_mon_volt <= rnd[7:0];
        i_mon_temp <= rnd[15:8];
        repeat (5) @(posedge i_clk_sys);
        rd_check("monitor", `REG_MONITOR, {16'h0, rnd[15:8], rnd[7:0]});
        // sleep with retention and tune-on-wake, then wake
        rnd = $random(seed);
        bus_wr(`REG_CONFIG, rnd);
        bus_wr(`REG_CTRL, 32'h3);
        @(posedge i_clk_sys);
        i_sleep <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        rd_check("status asleep", `REG_STATUS, 32'ha);
        rd_check("ctrl asleep", `REG_CTRL, 32'h0);
        bus_wr(`REG_CONFIG, ~rnd);
        @(posedge i_clk_sys);
        i_sleep <= 1'b0;
        wait_idle();
        rd_check("ctrl restored", `REG_CTRL, 32'h3);
        rd_check("config restored", `REG_CONFIG, rnd);
        ew = exp_word(`OTP_REG_TUNE_HIGH);
        check("tune", {24'h0, ew[7:0], exp_word(`OTP_REG_TUNE_LOW)},
            {24'h0, o_regulator_tune});
        rd_check("tune low", `REG_TUNE_LOW, exp_word(`OTP_REG_TUNE_LOW));
        // a second reset reloads the identifier and drops the retained copy
        @(posedge i_clk_sys);
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        wait_idle();
        check("uid again", {exp_word(11'h001), exp_word(11'h000)}, o_extended_unique_id);
        rd_check("ctrl after reset", `REG_CTRL, `CTRL_RESET);
        print_verdict();
    end
endmodule // calibration_otp_loader_tb

bind calibration_otp_loader calib_loader_props chk_u (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_otp_req(o_otp_req), .i_otp_rdata(i_otp_rdata),
    .o_extended_unique_id(o_extended_unique_id), .o_regulator_tune(o_regulator_tune),
    .o_crystal_trim(o_crystal_trim), .o_busy(o_busy));
